/* cmp_ctrl.sv */
// Analog comparator control with AHB-Lite register slave
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl
  import cmp_ctrl_pkg::*;
#(
  parameter int CHAN_W = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog comparator front end
  input wire logic cmp_out_async,
  output logic cmp_power_off,
  output logic pos_use_channel,
  output logic [CHAN_W-1:0] pos_channel,
  output logic [2:0] neg_select,
  // Interrupt request
  output logic cmp_irq
);
  logic [7:0] csr_b, csr, conv_ctrl, conv_mux, sys_ctrl;
  logic [7:0] next_csr_b, next_csr, next_conv_ctrl, next_conv_mux, next_sys_ctrl;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] rdata, next_rdata;
  logic ack_s1, ack_s2, ack_prev;
  logic next_ack_s1, next_ack_s2, next_ack_prev;
  logic ack_pulse;
  neg_sel_e neg;
  logic [2:0] next_out;
  logic next_pos_use_channel, next_cmp_irq, next_cmp_power_off;
  logic [CHAN_W-1:0] next_pos_channel;

  cmp_event_if ev ();
  cmp_event_detect u_det (
    .clk(clk),
    .rst_n(rst_n),
    .ev(ev)
  );

  // Comparator disabled means no decision; hold low
  assign ev.raw_cmp = cmp_out_async & ~csr[PWR_OFF_BIT];
  assign ev.mode = csr[MODE_LSB +: 2];

  // Result read straight from the synchroniser; a stored copy would lag one more cycle
  function automatic logic [7:0] csr_view(input logic [7:0] c, input logic r);
    csr_view = c;
    csr_view[RESULT_BIT] = r;
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    unique case (a)
      ADDR_CONV_CSR_B: read_mux = {24'h0, csr_b};
      ADDR_CMP_CSR: read_mux = {24'h0, csr_view(csr, ev.result)};
      ADDR_CONV_CTRL: read_mux = {24'h0, conv_ctrl};
      ADDR_CONV_MUX: read_mux = {24'h0, conv_mux};
      ADDR_SYS_CTRL: read_mux = {24'h0, sys_ctrl};
      default: read_mux = 32'h0;
    endcase
  endfunction

  wire take = hsel & hready & htrans[1];

  always_comb begin
    next_csr_b = csr_b;
    next_csr = csr;
    next_conv_ctrl = conv_ctrl;
    next_conv_mux = conv_mux;
    next_sys_ctrl = {sys_ctrl[7:2], 1'b0, sys_ctrl[0]};
    next_wr_pend = take & hwrite;
    next_wr_addr = take ? haddr : wr_addr;
    next_rdata = (take & ~hwrite) ? read_mux(haddr) : 32'h0;
    // Result bit not stored; reads take the synchroniser
    next_csr[RESULT_BIT] = 1'b0;
    if (wr_pend) begin
      unique case (wr_addr)
        ADDR_CONV_CSR_B: next_csr_b = {1'b0, hwdata[6:4], 4'h0};
        ADDR_CMP_CSR: begin
          next_csr[PWR_OFF_BIT] = hwdata[PWR_OFF_BIT];
          next_csr[IREF_SEL_BIT] = hwdata[IREF_SEL_BIT];
          next_csr[IRQ_EN_BIT] = hwdata[IRQ_EN_BIT];
          next_csr[2:0] = {1'b0, hwdata[MODE_LSB +: 2]};
          if (hwdata[FLAG_BIT]) begin
            next_csr[FLAG_BIT] = 1'b0;
          end
        end
        ADDR_CONV_CTRL: next_conv_ctrl = {hwdata[CONV_EN_BIT], 7'h0};
        ADDR_CONV_MUX: next_conv_mux = {hwdata[7:6], 1'b0, hwdata[4:0]};
        ADDR_SYS_CTRL: next_sys_ctrl = hwdata[7:0];
        default: ;
      endcase
    end
    if (ack_pulse) begin
      next_csr[FLAG_BIT] = 1'b0;
    end
    // Set wins over any clear in the same cycle
    if (ev.hit) begin
      next_csr[FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      csr_b <= REG_RESET;
      csr <= REG_RESET;
      conv_ctrl <= REG_RESET;
      conv_mux <= REG_RESET;
      sys_ctrl <= REG_RESET;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rdata <= 32'h0;
    end else begin
      csr_b <= next_csr_b;
      csr <= next_csr;
      conv_ctrl <= next_conv_ctrl;
      conv_mux <= next_conv_mux;
      sys_ctrl <= next_sys_ctrl;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      rdata <= next_rdata;
    end
  end

  // Vector acknowledge is a self-clearing bit written by the core, edge taken after sync
  always_comb begin
    next_ack_s1 = sys_ctrl[VACK_BIT];
    next_ack_s2 = ack_s1;
    next_ack_prev = ack_s2;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_prev <= 1'b0;
    end else begin
      ack_s1 <= next_ack_s1;
      ack_s2 <= next_ack_s2;
      ack_prev <= next_ack_prev;
    end
  end
  assign ack_pulse = ack_s2 & ~ack_prev;

  // Negative input selection
  always_comb begin
    if (!csr[IREF_SEL_BIT]) begin
      neg = NEG_PIN;
    end else if (conv_mux[REF_SRC_LSB +: 2] != REF_INTERNAL) begin
      neg = NEG_RESERVED;
    end else begin
      unique case (csr_b[REF_DIV_LSB +: 2])
        2'h0: neg = NEG_REF_FULL;
        2'h1: neg = NEG_REF_HALF;
        2'h2: neg = NEG_REF_QUARTER;
        default: neg = NEG_REF_EIGHTH;
      endcase
    end
  end

  // Out-of-range channel falls back to the pin rather than an undefined tap
  wire use_chan = csr_b[MUX_EN_BIT] & ~conv_ctrl[CONV_EN_BIT]
    & (conv_mux[CHAN_LSB +: 5] <= CHAN_MAX);

  always_comb begin
    next_out = 3'(neg);
    next_pos_use_channel = use_chan;
    if (use_chan) begin
      next_pos_channel = CHAN_W'(conv_mux[CHAN_LSB +: 5]);
    end else begin
      next_pos_channel = '0;
    end
    next_cmp_irq = next_csr[FLAG_BIT] & csr[IRQ_EN_BIT] & sys_ctrl[GIE_BIT];
    next_cmp_power_off = csr[PWR_OFF_BIT];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_use_channel <= 1'b0;
      pos_channel <= '0;
      neg_select <= 3'h0;
      cmp_irq <= 1'b0;
      cmp_power_off <= 1'b0;
    end else begin
      pos_use_channel <= next_pos_use_channel;
      pos_channel <= next_pos_channel;
      neg_select <= next_out;
      cmp_irq <= next_cmp_irq;
      cmp_power_off <= next_cmp_power_off;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata;
endmodule
`default_nettype wire

/* cmp_ctrl_pkg.sv */
// Shared constants for the analog comparator control block
package cmp_ctrl_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONV_CSR_B = 8'h00;
  localparam logic [7:0] ADDR_CMP_CSR = 8'h04;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CONV_MUX = 8'h0c;
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h10;
  // converter_control_status_b fields
  localparam int MUX_EN_BIT = 6;
  localparam int REF_DIV_LSB = 4;
  // comparator_control_status fields
  localparam int PWR_OFF_BIT = 7;
  localparam int IREF_SEL_BIT = 6;
  localparam int RESULT_BIT = 5;
  localparam int FLAG_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int MODE_LSB = 0;
  // Other fields
  localparam int CONV_EN_BIT = 7;
  localparam int CHAN_LSB = 0;
  localparam int REF_SRC_LSB = 6;
  localparam int GIE_BIT = 0;
  localparam int VACK_BIT = 1;
  // Codes and reset values
  localparam logic [4:0] CHAN_MAX = 5'h0a;
  localparam logic [1:0] REF_INTERNAL = 2'h3;
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Negative input selections
  typedef enum logic [2:0] {
    NEG_PIN, NEG_REF_FULL, NEG_REF_HALF, NEG_REF_QUARTER, NEG_REF_EIGHTH, NEG_RESERVED
  } neg_sel_e;
endpackage

/* cmp_event_if.sv */
// Carrier between the control top and the event detector
`timescale 1ns/1ps
`default_nettype none
interface cmp_event_if;
  logic raw_cmp;
  logic [1:0] mode;
  logic result;
  logic hit;
  modport ctrl (output raw_cmp, output mode, input result, input hit);
  modport det (input raw_cmp, input mode, output result, output hit);
endinterface
`default_nettype wire

/* cmp_event_detect.sv */
// Comparator output synchroniser and event detector
`timescale 1ns/1ps
`default_nettype none
module cmp_event_detect
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Carrier
  cmp_event_if.det ev
);
  logic sync_a, sync_b, prev;
  logic next_sync_a, next_sync_b, next_prev;

  always_comb begin
    next_sync_a = ev.raw_cmp;
    next_sync_b = sync_a;
    next_prev = sync_b;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      prev <= next_prev;
    end
  end

  assign ev.result = sync_b;

  // Compare current and previous synchronised sample
  always_comb begin
    unique case (ev.mode)
      MODE_TOGGLE: ev.hit = sync_b ^ prev;
      MODE_FALL: ev.hit = prev & ~sync_b;
      MODE_RISE: ev.hit = sync_b & ~prev;
      default: ev.hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* cmp_front_model.sv */
// Behavioural analog front end: pins, channels and reference
`timescale 1ns/1ps
`default_nettype none
module cmp_front_model (
  // From the block
  input wire logic off,
  input wire logic use_ch,
  input wire logic [4:0] chan,
  input wire logic [2:0] nsel,
  // Pin levels in mV, decision
  input wire logic [11:0] pos_mv,
  input wire logic [11:0] neg_mv,
  output logic raw
);
  // Channel n sits at n*128 mV, so each code gives a distinct level
  assign raw = !off && ((use_ch ? {chan, 7'h00} : pos_mv) >
    (nsel == 3'h0 ? neg_mv : 12'ha00 >> (nsel - 3'h1)));
endmodule
`default_nettype wire

/* cmp_ctrl_assertions.sv */
// Port checker for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_assertions
  import cmp_ctrl_pkg::*;
#(parameter int CHAN_W = 5) (
  // Clock, reset, bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Front end and request
  input wire logic cmp_power_off,
  input wire logic pos_use_channel,
  input wire logic [CHAN_W-1:0] pos_channel,
  input wire logic cmp_irq
);
  logic wr;
  logic [7:0] wa;
  logic wc, ws;
  // Data phase of a write; zero wait states
  always_ff @(posedge clk) begin
    wr <= rst_n && hsel && hready && htrans[1] && hwrite;
    wa <= haddr;
  end
  assign wc = wr && wa == ADDR_CMP_CSR;
  assign ws = wr && wa == ADDR_SYS_CTRL;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RST: assert property (disable iff (1'b0)
    !rst_n |=> !cmp_irq && !cmp_power_off && !pos_use_channel) else $error("reset");
  AST_PWR: assert property (wc |-> ##2 cmp_power_off == $past(hwdata[7], 2))
    else $error("power bit");
  AST_HOLD: assert property (!wc |-> ##2 $stable(cmp_power_off))
    else $error("power moved");
  AST_W1C: assert property (wc && hwdata[4] |-> ##[1:4] !cmp_irq)
    else $error("flag kept");
  AST_ACK: assert property (ws && hwdata[1] |-> ##[1:6] !cmp_irq)
    else $error("ack ignored");
  AST_GIE: assert property (ws && !hwdata[0] |-> ##[1:2] !cmp_irq)
    else $error("global mask");
  AST_EN: assert property (wc && !hwdata[3] |-> ##[1:2] !cmp_irq)
    else $error("local mask");
  AST_CHAN: assert property (
    pos_use_channel ? pos_channel <= CHAN_MAX : pos_channel == '0) else $error("channel");
  cover property ($rose(cmp_irq));
  cover property ($rose(cmp_power_off));
  cover property (pos_use_channel);
endmodule
bind cmp_ctrl cmp_ctrl_assertions #(.CHAN_W(CHAN_W)) u_chk (.clk, .rst_n, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .cmp_power_off, .pos_use_channel, .pos_channel, .cmp_irq);
`default_nettype wire

/* testbench.sv */
// Bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cmp_ctrl_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, rdy, irq, off, use_ch, raw, resp;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [11:0] pos_mv = 12'h000;
  logic [4:0] chan;
  logic [2:0] nsel;
  int err_total = 0, checks = 0;
  always #20 clk = ~clk;
  cmp_ctrl u_dut (.clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(rdy), .hrdata, .hreadyout(rdy), .hresp(resp), .cmp_out_async(raw),
    .cmp_power_off(off), .pos_use_channel(use_ch), .pos_channel(chan), .neg_select(nsel),
    .cmp_irq(irq));
  cmp_front_model u_front (.off, .use_ch, .chan, .nsel, .pos_mv, .neg_mv(12'h3e8), .raw);
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    checks++;
    if (v !== e) begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, v, e);
    end
  endtask
  task automatic wt;
    int n = 0;
    do @(posedge clk); while (rdy !== 1'b1 && ++n < 20);
    if (rdy !== 1'b1) begin
      err_total++;
      end_sim;
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wt;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    rd = hrdata;
    // Registered outputs need the edge after the write
    if (w) repeat (2) @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 32'h0, 1'b0);
    chk(rd, e);
    chk(resp, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 24; a += 4) rc(8'(a), 32'h0);
    $display("reset done");
    bus(ADDR_CONV_CSR_B, 32'h40);
    bus(ADDR_CONV_MUX, 32'hca);
    chk({use_ch, chan}, 6'h2a);
    bus(ADDR_CONV_CTRL, 32'h80);
    chk({use_ch, chan}, 6'h00);
    bus(ADDR_CMP_CSR, 32'h40);
    for (int d = 0; d < 4; d++) begin
      bus(ADDR_CONV_CSR_B, 32'h40 | d << 4);
      chk(nsel, d + 1);
    end
    rc(ADDR_CONV_CSR_B, 32'h70);
    bus(ADDR_CONV_MUX, 32'h0a);
    chk(nsel, 3'h5);
    bus(ADDR_CMP_CSR, 32'h00);
    chk(nsel, 3'h0);
    $display("select done");
    bus(ADDR_SYS_CTRL, 32'h1);
    for (int m = 0; m < 4; m++) begin
      bus(ADDR_CMP_CSR, 32'h10 | m);
      bus(ADDR_CMP_CSR, 32'h18 | m);
      pos_mv <= 12'h7d0;
      repeat (8) @(posedge clk);
      chk(irq, m == 0 || m == 3);
      bus(ADDR_CMP_CSR, 32'h08 | m);
      rc(ADDR_CMP_CSR, 32'h28 | m | (m == 0 || m == 3) << 4);
      bus(ADDR_CMP_CSR, 32'h18 | m);
      pos_mv <= 12'h000;
      repeat (8) @(posedge clk);
      chk(irq, m == 0 || m == 2);
    end
    pos_mv <= 12'h7d0;
    repeat (8) @(posedge clk);
    bus(ADDR_SYS_CTRL, 32'h0);
    chk(irq, 1'b0);
    bus(ADDR_SYS_CTRL, 32'h1);
    chk(irq, 1'b1);
    bus(ADDR_SYS_CTRL, 32'h3);
    repeat (4) @(posedge clk);
    chk(irq, 1'b0);
    rc(ADDR_SYS_CTRL, 32'h1);
    bus(ADDR_CMP_CSR, 32'h03);
    bus(ADDR_CMP_CSR, 32'h83);
    chk(off, 1'b1);
    rc(ADDR_CMP_CSR, 32'h83);
    bus(ADDR_CMP_CSR, 32'h03);
    chk(off, 1'b0);
    $display("event done");
    end_sim;
  end
endmodule
`default_nettype wire
